//--- bnv_host.sv
`timescale 1ns/1ps
module bnv_host
    import bnv_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              clk_en,
    // Supply-good pin from the supply monitor.
    input  wire logic              supply_ok,
    // User request.
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    // User answer.
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    // Memory pins.
    output logic                   mem_sel_n,
    output logic                   mem_oe_n,
    output logic                   mem_we_n,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [DATA_W-1:0]      mem_dq_out,
    output logic                   mem_dq_oe,
    input  wire logic [DATA_W-1:0] mem_dq_in
);

    ////////////////////////////////////////////////////////////////////////
    // All state of the controller.
    typedef struct packed {
        bnv_state_t        state;
        logic [CNT_W-1:0]  cnt;
        logic              write;
        logic [DATA_W-1:0] wdata;
        logic              ok_meta;
        logic              ok_sync;
        logic [DATA_W-1:0] dq_meta;
        logic [DATA_W-1:0] dq_sync;
        logic              req_ready;
        logic              rsp_valid;
        logic [DATA_W-1:0] rsp_rdata;
        logic              sel_n;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
        logic              dq_oe;
    } bnv_regs_t;

    bnv_regs_t r;
    bnv_regs_t next_r;

    // Counter step, used in both timed states.
    function automatic logic [CNT_W-1:0] bnv_inc(input logic [CNT_W-1:0] c);
        bnv_inc = c + CNT_ONE;
    endfunction : bnv_inc

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb
    begin
        next_r           = r;
        next_r.ok_meta   = supply_ok;
        next_r.ok_sync   = r.ok_meta;
        next_r.dq_meta   = mem_dq_in;
        next_r.dq_sync   = r.dq_meta;
        next_r.rsp_valid = 1'b0;
        unique case (r.state)
            BNV_IDLE:
            begin
                next_r.req_ready = r.ok_sync;
                // Start only on valid request and good supply.
                if (req_valid && r.req_ready && r.ok_sync)
                begin
                    next_r.state     = BNV_ACTIVE;
                    next_r.cnt       = CNT_ZERO;
                    next_r.req_ready = 1'b0;
                    next_r.write     = req_write;
                    next_r.wdata     = req_wdata;
                    next_r.addr      = req_addr;
                    // Select falls on the same edge that loads the address.
                    next_r.sel_n     = 1'b0;
                    next_r.oe_n      = req_write;
                end
            end
            BNV_ACTIVE:
            begin
                next_r.cnt = bnv_inc(r.cnt);
                if (r.write && r.cnt == WRITE_START)
                begin
                    next_r.we_n  = 1'b0;
                    next_r.dq_oe = 1'b1;
                end
                // Write strobe rises while select is still low, so the
                // write ends on its own edge and not in a tie with select.
                if (r.write && r.cnt == WRITE_END)
                    next_r.we_n = 1'b1;
                // Sample data after both access times.
                if (!r.write && r.cnt == SAMPLE_AT)
                    next_r.rsp_rdata = r.dq_sync;
                // Fixed low time inside the legal window.
                if (r.cnt == ACTIVE_LAST)
                begin
                    next_r.state     = BNV_PRE;
                    next_r.cnt       = CNT_ZERO;
                    next_r.sel_n     = 1'b1;
                    next_r.oe_n      = 1'b1;
                    next_r.we_n      = 1'b1;
                    next_r.rsp_valid = 1'b1;
                end
            end
            BNV_PRE:
            begin
                // Precharge held before the next access.
                next_r.cnt = bnv_inc(r.cnt);
                if (r.cnt == HOLD_LAST)
                    next_r.dq_oe = 1'b0;
                if (r.cnt == PRE_LAST)
                begin
                    next_r.state     = BNV_IDLE;
                    next_r.req_ready = r.ok_sync;
                end
            end
            default:
            begin
                next_r.state = BNV_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register with synchronous reset and clock enable.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            r       <= '0;
            r.state <= BNV_IDLE;
            r.sel_n <= 1'b1;
            r.oe_n  <= 1'b1;
            r.we_n  <= 1'b1;
        end
        else if (clk_en)
            r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.
    assign req_ready  = r.req_ready;
    assign rsp_valid  = r.rsp_valid;
    assign rsp_rdata  = r.rsp_rdata;
    assign mem_sel_n  = r.sel_n;
    assign mem_oe_n   = r.oe_n;
    assign mem_we_n   = r.we_n;
    assign mem_addr   = r.addr;
    assign mem_dq_out = r.wdata;
    assign mem_dq_oe  = r.dq_oe;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the pin timing, counted in enabled cycles.
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] high_cnt;

    // Saturating step, so a long idle span reads as ample precharge
    // instead of wrapping back to a small count.
    function automatic logic [CNT_W-1:0] bnv_sat(input logic [CNT_W-1:0] c);
        bnv_sat = (c == CNT_FULL) ? c : bnv_inc(c);
    endfunction : bnv_sat

    // High count starts full: reset itself is a long precharge.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            low_cnt  <= CNT_ZERO;
            high_cnt <= CNT_FULL;
        end
        else if (clk_en)
        begin
            low_cnt  <= r.sel_n ? CNT_ZERO : bnv_sat(low_cnt);
            high_cnt <= r.sel_n ? bnv_sat(high_cnt) : CNT_ZERO;
        end
    end

    sequence s_sel_fall;
        $fell(r.sel_n);
    endsequence

    property p_low_time;
        @(posedge clock) disable iff (!rstn)
        ($rose(r.sel_n) && clk_en) |-> low_cnt == ACTIVE_LAST + CNT_ONE;
    endproperty

    chk_select_low_time: assert property (p_low_time)
        else $error("Select low time differs from the planned count.");
    chk_select_low_bound: assert property (
        @(posedge clock) disable iff (!rstn)
        low_cnt <= ACTIVE_LAST + CNT_ONE)
        else $error("Select held low too long.");
    chk_precharge_time: assert property (
        @(posedge clock) disable iff (!rstn)
        s_sel_fall |-> high_cnt >= CNT_W'(PRECHARGE_MIN_CYC))
        else $error("Precharge shorter than the minimum.");
    chk_cycle_period: assert property (
        @(posedge clock) disable iff (!rstn)
        s_sel_fall |-> int'(high_cnt) + ACTIVE_CYC >= READ_PERIOD_MIN_CYC)
        else $error("Cycle period shorter than the minimum.");
    chk_supply_gate: assert property (
        @(posedge clock) disable iff (!rstn)
        s_sel_fall |-> $past(r.ok_sync))
        else $error("Access started with supply not good.");
    chk_request_start: assert property (
        @(posedge clock) disable iff (!rstn)
        s_sel_fall |-> $past(req_valid) && $past(req_ready))
        else $error("Select fell without a taken request.");
    chk_addr_stable: assert property (
        @(posedge clock) disable iff (!rstn)
        !r.sel_n && !$fell(r.sel_n) |-> $stable(r.addr))
        else $error("Address moved while select low.");
    chk_read_answer: assert property (
        @(posedge clock) disable iff (!rstn)
        $rose(r.sel_n) && !r.write |-> r.rsp_valid)
        else $error("Read answer missing at select rise.");
    chk_drive_window: assert property (
        @(posedge clock) disable iff (!rstn)
        r.write |-> r.oe_n)
        else $error("Output drive low during a write.");
    chk_access_pair: assert property (
        @(posedge clock) disable iff (!rstn)
        r.state == BNV_PRE |-> r.sel_n)
        else $error("Select low during precharge.");

endmodule : bnv_host

//--- bnv_mem_model.sv
`timescale 1ns/1ps
module bnv_mem_model
    import bnv_pkg::*;
(
    // Memory pins driven by the host.
    input  wire logic              mem_sel_n,
    input  wire logic              mem_oe_n,
    input  wire logic              mem_we_n,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] mem_dq_out,
    input  wire logic              mem_dq_oe,
    // Data bus level seen by the host and count of timing faults.
    output logic [DATA_W-1:0]      mem_dq_in,
    output int                     viol
);
    logic [DATA_W-1:0] ram [0:(1<<ADDR_W)-1];
    logic [ADDR_W-1:0] lat;
    realtime           t_fall;
    realtime           t_rise;
    realtime           t_oe;

    // Start with no history so the first access is judged fairly.
    initial
    begin
        viol = 0;
        t_fall = -1000.0;
        t_rise = -1000.0;
        t_oe = 0.0;
        lat = '0;
        mem_dq_in = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Address latch, precharge check.
    // Precharge and cycle spacing are flagged when short.
    always @(negedge mem_sel_n)
    begin
        if ($realtime - t_rise < PRECHARGE_MIN_NS) viol++;
        if ($realtime - t_fall < READ_PERIOD_MIN_NS) viol++;
        t_fall = $realtime;
        lat = mem_addr;
    end

    // Select low window bounded.
    // A write still pending when select rises lands here.
    always @(posedge mem_sel_n)
    begin
        if ($realtime - t_fall < SELECT_ACTIVE_MIN_NS) viol++;
        if ($realtime - t_fall > SELECT_ACTIVE_MAX_NS) viol++;
        if (!mem_we_n && mem_dq_oe) ram[lat] = mem_dq_out;
        t_rise = $realtime;
    end

    // A write ends on the rising write strobe inside the select window.
    always @(posedge mem_we_n)
        if (!mem_sel_n && mem_dq_oe) ram[lat] = mem_dq_out;

    // Output drive falls start the drive access time.
    always @(negedge mem_oe_n)
        t_oe = $realtime;

    ////////////////////////////////////////////////////////////////////////
    // Data valid only after both access times.
    // Any supply level is served; outside valid data the bus toggles.
    always #1
    begin
        if (!mem_sel_n && !mem_oe_n && mem_we_n
            && $realtime - t_fall >= SELECT_TO_DATA_NS
            && $realtime - t_oe >= DRIVE_TO_DATA_NS)
            mem_dq_in = ram[lat];
        else
            mem_dq_in = ~mem_dq_in;
    end
endmodule : bnv_mem_model

//--- bnv_pkg.sv
package bnv_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths of the memory port.
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // Clock rate and timing figures in nanoseconds.
    localparam int CLK_PERIOD_NS          = 10;
    localparam int SELECT_ACTIVE_MIN_NS   = 120;
    localparam int SELECT_ACTIVE_MAX_NS   = 10000;
    localparam int SELECT_TO_DATA_NS      = 120;
    localparam int DRIVE_TO_DATA_NS       = 10;
    localparam int READ_PERIOD_MIN_NS     = 180;
    localparam int PRECHARGE_MIN_NS       = 60;
    localparam int ADDR_HOLD_NS           = 10;

    ////////////////////////////////////////////////////////////////////////
    // Cycle counts; least times round up, longest times round down.
    localparam int SELECT_ACTIVE_MIN_CYC =
        (SELECT_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELECT_ACTIVE_MAX_CYC =
        SELECT_ACTIVE_MAX_NS / CLK_PERIOD_NS;
    localparam int SELECT_TO_DATA_CYC =
        (SELECT_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DRIVE_TO_DATA_CYC =
        (DRIVE_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRECHARGE_MIN_CYC =
        (PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_PERIOD_MIN_CYC =
        (READ_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_HOLD_CYC =
        (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Two flops sit between the data pins and the read register.
    localparam int SYNC_CYC = 2;
    // Read strobe window: the pins are caught once both access times
    // have passed, and the synchronised copy is taken two cycles later.
    localparam int DATA_SAMPLE_CYC = SYNC_CYC +
        ((SELECT_TO_DATA_CYC > DRIVE_TO_DATA_CYC + 1) ?
        SELECT_TO_DATA_CYC : DRIVE_TO_DATA_CYC + 1);
    // Select stays low for the longer of the active minimum and the sample cycle plus one.
    localparam int ACTIVE_CYC = (DATA_SAMPLE_CYC + 1 > SELECT_ACTIVE_MIN_CYC)
        ? DATA_SAMPLE_CYC + 1 : SELECT_ACTIVE_MIN_CYC;
    // Precharge stretched so the whole cycle meets the period minimum.
    localparam int PRE_CYC =
        (READ_PERIOD_MIN_CYC - ACTIVE_CYC > PRECHARGE_MIN_CYC) ?
        READ_PERIOD_MIN_CYC - ACTIVE_CYC : PRECHARGE_MIN_CYC;

    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h1f;
    localparam logic [CNT_W-1:0] ACTIVE_LAST = CNT_W'(ACTIVE_CYC - 1);
    localparam logic [CNT_W-1:0] SAMPLE_AT   = CNT_W'(DATA_SAMPLE_CYC);
    localparam logic [CNT_W-1:0] HOLD_LAST   = CNT_W'(ADDR_HOLD_CYC);
    localparam logic [CNT_W-1:0] PRE_LAST    = CNT_W'(PRE_CYC - 1);

    // Write pulse starts two cycles after select falls.
    localparam logic [CNT_W-1:0] WRITE_START = 5'h01;
    // Write pulse ends one cycle before select rises.
    localparam logic [CNT_W-1:0] WRITE_END   = CNT_W'(ACTIVE_CYC - 2);

    ////////////////////////////////////////////////////////////////////////
    // Controller states, Gray coded along idle, active, precharge.
    typedef enum logic [1:0] {
        BNV_IDLE   = 2'b00,
        BNV_ACTIVE = 2'b01,
        BNV_PRE    = 2'b11
    } bnv_state_t;

endpackage : bnv_pkg

//--- bytewide_nv_ram_access_tb_top.sv
`timescale 1ns/1ps
`define BNV_CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
    errors++; $display("[FAIL] %0t value mismatch", $time); end end
module bytewide_nv_ram_access_tb_top;
    import bnv_pkg::*;
    logic clock = 0, rstn = 0, clk_en = 1, supply_ok = 1;
    logic req_valid = 0, req_write = 0, req_ready, rsp_valid;
    logic [ADDR_W-1:0] req_addr = '0, mem_addr;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, mem_dq_out, mem_dq_in, q;
    logic mem_sel_n, mem_oe_n, mem_we_n, mem_dq_oe;
    int errors = 0, num_checks = 0, viol, i;

    // Clock at 100 MHz.
    always #5 clock = ~clock;

    bnv_host dut (.clock(clock), .rstn(rstn), .clk_en(clk_en),
        .supply_ok(supply_ok), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_sel_n(mem_sel_n),
        .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_addr(mem_addr),
        .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
        .mem_dq_in(mem_dq_in));
    bnv_mem_model mem (.mem_sel_n(mem_sel_n), .mem_oe_n(mem_oe_n),
        .mem_we_n(mem_we_n), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
        .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in), .viol(viol));

    ////////////////////////////////////////////////////////////////////////
    // Prints the verdict and stops the run.
    task automatic conclude;
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // Steps to just after the n-th next rising edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // One access; the address moves after the take to prove the latch.
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin tick(1); n++; end
        req_valid = 1; req_write = w; req_addr = a; req_wdata = d;
        tick(1);
        req_valid = 0; req_addr = ~a; req_wdata = ~d;
        n = 0;
        while (mem_sel_n !== 1'b0 && n < 10) begin tick(1); n++; end
        `BNV_CHK(mem_addr, a)
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin tick(1); n++; end
        `BNV_CHK(rsp_valid, 1'b1)
        `BNV_CHK(mem_sel_n, 1'b1)
        q = rsp_rdata;
    endtask : access

    ////////////////////////////////////////////////////////////////////////
    // Back-to-back writes then reads at the address edges and alternating patterns.
    task automatic t_rw;
        logic [ADDR_W-1:0] at [4];
        at = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
        for (i = 0; i < 4; i++) access(1'b1, at[i], 8'h5a ^ 8'(i * 37));
        for (i = 0; i < 4; i++)
        begin
            access(1'b0, at[i], 8'h00);
            `BNV_CHK(q, 8'h5a ^ 8'(i * 37))
        end
    endtask : t_rw

    // Supply low refuses new accesses and leaves select high.
    task automatic t_supply;
        supply_ok = 0;
        tick(10);
        `BNV_CHK(req_ready, 1'b0)
        req_valid = 1; req_write = 1; req_addr = 13'h0aaa;
        for (i = 0; i < 10; i++)
        begin
            tick(1);
            `BNV_CHK(mem_sel_n, 1'b1)
        end
        req_valid = 0;
        supply_ok = 1;
        access(1'b0, 13'h0aaa, 8'h00);
        `BNV_CHK(q, 8'h5a ^ 8'(2 * 37))
    endtask : t_supply

    // Clock enable low mid-read freezes select, then the read completes.
    task automatic t_clken;
        access(1'b1, 13'h1234, 8'hc3);
        while (req_ready !== 1'b1) tick(1);
        req_valid = 1; req_write = 0; req_addr = 13'h1234;
        tick(1);
        req_valid = 0;
        tick(4);
        clk_en = 0;
        for (i = 0; i < 20; i++)
        begin
            tick(1);
            `BNV_CHK(mem_sel_n, 1'b0)
        end
        clk_en = 1;
        i = 0;
        while (rsp_valid !== 1'b1 && i < 40) begin tick(1); i++; end
        `BNV_CHK(rsp_rdata, 8'hc3)
    endtask : t_clken

    ////////////////////////////////////////////////////////////////////////
    // Reset for 12 cycles, then the scenarios and the timing fault count.
    initial
    begin
        tick(12);
        rstn = 1;
        t_rw();
        t_supply();
        t_clken();
        tick(10);
        `BNV_CHK(viol, 0)
        conclude();
    end

    // Watchdog cuts a hang short.
    initial
    begin
        #200000;
        errors++;
        conclude();
    end
endmodule : bytewide_nv_ram_access_tb_top
